/* File: rtl/cold_load_pickup_regs.svh */
// Register map, field positions, reset values and timing of the supervisor
`ifndef COLD_LOAD_PICKUP_REGS_SVH
`define COLD_LOAD_PICKUP_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define COLD_LOAD_PICKUP_OFS_CTRL        8'h00
`define COLD_LOAD_PICKUP_OFS_STATUS      8'h04
`define COLD_LOAD_PICKUP_OFS_UC_THR      8'h08
`define COLD_LOAD_PICKUP_OFS_INRUSH_THR  8'h0C
`define COLD_LOAD_PICKUP_OFS_T_LOAD_OFF  8'h10
`define COLD_LOAD_PICKUP_OFS_T_SETTLE    8'h14
`define COLD_LOAD_PICKUP_OFS_T_MAX_BLOCK 8'h18
`define COLD_LOAD_PICKUP_OFS_IRQ_STATUS  8'h1C
`define COLD_LOAD_PICKUP_OFS_IRQ_MASK    8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define COLD_LOAD_PICKUP_CTRL_EN_BIT       0
`define COLD_LOAD_PICKUP_CTRL_MODE_LSB     1
`define COLD_LOAD_PICKUP_CTRL_EXT_SEL_BIT  3
`define COLD_LOAD_PICKUP_CTRL_INT_SEL_BIT  4
`define COLD_LOAD_PICKUP_IRQ_ENGAGED_BIT   0
`define COLD_LOAD_PICKUP_IRQ_SETTLED_BIT   1
`define COLD_LOAD_PICKUP_IRQ_MAXBLK_BIT    2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define COLD_LOAD_PICKUP_RST_MODE        2'h0
`define COLD_LOAD_PICKUP_RST_UC_THR      16'h0010
`define COLD_LOAD_PICKUP_RST_INRUSH_THR  16'h1000
`define COLD_LOAD_PICKUP_RST_T_LOAD_OFF  16'h03E8
`define COLD_LOAD_PICKUP_RST_T_SETTLE    16'h0064
`define COLD_LOAD_PICKUP_RST_T_MAX_BLOCK 16'h0BB8
`define COLD_LOAD_PICKUP_RST_IRQ_MASK    3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define COLD_LOAD_PICKUP_CLK_PERIOD_NS   20
`define COLD_LOAD_PICKUP_TICK_US         1000
`define COLD_LOAD_PICKUP_INRUSH_DROP_NUM 9
`define COLD_LOAD_PICKUP_INRUSH_DROP_DEN 10

`endif

/* File: rtl/cold_load_pickup_pkg.sv */
// Types shared by the cold load pickup supervisor
package cold_load_pickup_pkg;

    typedef enum logic [1:0] {
        MODE_BKR_OPEN,
        MODE_UNDERCUR,
        MODE_OPEN_AND_UC,
        MODE_OPEN_OR_UC
    } breaker_position_mode_t;

    typedef enum logic [2:0] {
        ST_WARM,
        ST_LOAD_OFF,
        ST_COLD,
        ST_RELEASE
    } cold_load_pickup_state_t;

    typedef struct packed {
        cold_load_pickup_state_t            st;
        logic                   en;
        breaker_position_mode_t mode;
        logic                   ext_sel;
        logic                   int_sel;
        logic [15:0]            uc_thr;
        logic [15:0]            inrush_thr;
        logic [15:0]            t_load_off;
        logic [15:0]            t_settle;
        logic [15:0]            t_max_block;
        logic [2:0]             irq_st;
        logic [2:0]             irq_mask;
        logic [31:0]            rdata;
        logic                   err;
        logic [19:0]            tick_cnt;
        logic                   inrush_seen;
    } cold_load_pickup_regs_t;

endpackage

/* File: rtl/cold_load_pickup_delay_timer.sv */
// Tick counter that reports when a programmed delay has elapsed
`timescale 1ns/100ps
`default_nettype none

module cold_load_pickup_delay_timer #(
    parameter int W = 16
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic         clr_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] limit_i,
    output logic              done_o
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Refused while elaborating, not at run time
    if (W < 2 || W > 32) begin : g_width_chk
        $error("timer width out of range");
    end

    assign done_o = (cnt_q >= limit_i);

    // Saturates at the limit so done stays until cleared
    always_comb begin
        cnt_d = cnt_q;
        if (clr_i) begin
            cnt_d = '0;
        end else if (tick_i && !done_o) begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/cold_load_pickup_current_cmp.sv */
// Current magnitude against undercurrent and inrush thresholds
`timescale 1ns/100ps
`default_nettype none
`include "cold_load_pickup_regs.svh"

module cold_load_pickup_current_cmp #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] current_i,
    input  wire logic [W-1:0] uc_thr_i,
    input  wire logic [W-1:0] inrush_thr_i,
    output logic              under_o,
    output logic              over_o,
    output logic              below_drop_o
);

    logic [W+3:0] cur_scaled;
    logic [W+3:0] thr_scaled;

    // Product must fit W+4 bits
    if (W < 4 || W > 28) begin : g_width_chk
        $error("current width out of range");
    end

    // Scaled compare avoids a divider for the 90 percent point
    assign cur_scaled   = (W+4)'(current_i) * (W+4)'(`COLD_LOAD_PICKUP_INRUSH_DROP_DEN);
    assign thr_scaled   = (W+4)'(inrush_thr_i) * (W+4)'(`COLD_LOAD_PICKUP_INRUSH_DROP_NUM);
    assign under_o      = (current_i < uc_thr_i);
    assign over_o       = (current_i > inrush_thr_i);
    assign below_drop_o = (cur_scaled <= thr_scaled);

endmodule

`default_nettype wire

/* File: rtl/cold_load_pickup_top.sv */
// Cold load pickup supervisor with APB registers and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "cold_load_pickup_regs.svh"

module cold_load_pickup_top #(
    parameter int TICK_CYC = `COLD_LOAD_PICKUP_TICK_US * 1000 / `COLD_LOAD_PICKUP_CLK_PERIOD_NS
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        breaker_closed_i,
    input  wire logic [15:0] current_mag_i,
    input  wire logic        ext_block_i,
    input  wire logic        int_block_i,
    input  wire logic        auto_reclose_running_i,
    output logic             cold_load_enable_out_o,
    output logic             inrush_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Tick counter is 20 bits wide
    if (TICK_CYC < 1 || TICK_CYC > (1 << 20)) begin : g_tick_chk
        $error("TICK_CYC out of range");
    end

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            `COLD_LOAD_PICKUP_OFS_CTRL, `COLD_LOAD_PICKUP_OFS_STATUS, `COLD_LOAD_PICKUP_OFS_UC_THR,
            `COLD_LOAD_PICKUP_OFS_INRUSH_THR, `COLD_LOAD_PICKUP_OFS_T_LOAD_OFF,
            `COLD_LOAD_PICKUP_OFS_T_SETTLE, `COLD_LOAD_PICKUP_OFS_T_MAX_BLOCK,
            `COLD_LOAD_PICKUP_OFS_IRQ_STATUS, `COLD_LOAD_PICKUP_OFS_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    function automatic logic cold_detect(
        input cold_load_pickup_pkg::breaker_position_mode_t m,
        input logic open_c,
        input logic under_c
    );
        unique case (m)
            cold_load_pickup_pkg::MODE_BKR_OPEN:    cold_detect = open_c;
            cold_load_pickup_pkg::MODE_UNDERCUR:    cold_detect = under_c;
            cold_load_pickup_pkg::MODE_OPEN_AND_UC: cold_detect = open_c & under_c;
            cold_load_pickup_pkg::MODE_OPEN_OR_UC:  cold_detect = open_c | under_c;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------
    cold_load_pickup_pkg::cold_load_pickup_regs_t s_q;
    cold_load_pickup_pkg::cold_load_pickup_regs_t s_d;

    logic       under;
    logic       over;
    logic       below_drop;
    logic       cold;
    logic       blocked;
    logic       tick;
    logic       lo_done;
    logic       set_done;
    logic       mb_done;
    logic       lo_clr;
    logic       set_clr;
    logic       mb_clr;
    logic       setup;
    logic       wr;
    logic [2:0] evt;
    logic [2:0] w1c;

    cold_load_pickup_current_cmp #(
        .W (16)
    ) u_cmp (
        .current_i    (current_mag_i),
        .uc_thr_i     (s_q.uc_thr),
        .inrush_thr_i (s_q.inrush_thr),
        .under_o      (under),
        .over_o       (over),
        .below_drop_o (below_drop)
    );

    assign cold    = cold_detect(s_q.mode, !breaker_closed_i, under);
    assign blocked = !s_q.en
                   | (s_q.ext_sel & ext_block_i)
                   | (s_q.int_sel & int_block_i)
                   | auto_reclose_running_i;
    assign tick    = (s_q.tick_cnt == 20'(TICK_CYC - 1));

    // ------------------------------------------------------------------
    // Delay timers
    // ------------------------------------------------------------------
    assign lo_clr  = (s_q.st != cold_load_pickup_pkg::ST_LOAD_OFF);
    assign mb_clr  = (s_q.st != cold_load_pickup_pkg::ST_RELEASE);
    // Any rise over the drop point restarts the settle period
    assign set_clr = mb_clr | !below_drop;

    cold_load_pickup_delay_timer #(
        .W (16)
    ) u_load_off (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .clr_i   (lo_clr),
        .tick_i  (tick),
        .limit_i (s_q.t_load_off),
        .done_o  (lo_done)
    );

    cold_load_pickup_delay_timer #(
        .W (16)
    ) u_settle (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .clr_i   (set_clr),
        .tick_i  (tick),
        .limit_i (s_q.t_settle),
        .done_o  (set_done)
    );

    cold_load_pickup_delay_timer #(
        .W (16)
    ) u_max_block (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .clr_i   (mb_clr),
        .tick_i  (tick),
        .limit_i (s_q.t_max_block),
        .done_o  (mb_done)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    assign setup = psel_i & ~penable_i;
    assign wr    = psel_i & penable_i & pwrite_i;

    always_comb begin
        s_d = s_q;
        evt = 3'h0;
        w1c = 3'h0;
        s_d.tick_cnt = tick ? 20'h00000 : s_q.tick_cnt + 20'h00001;

        unique case (s_q.st)
            cold_load_pickup_pkg::ST_WARM: begin
                if (cold) begin
                    s_d.st = cold_load_pickup_pkg::ST_LOAD_OFF;
                end
            end
            cold_load_pickup_pkg::ST_LOAD_OFF: begin
                if (!cold) begin
                    s_d.st = cold_load_pickup_pkg::ST_WARM;
                end else if (lo_done) begin
                    s_d.st = cold_load_pickup_pkg::ST_COLD;
                    evt[`COLD_LOAD_PICKUP_IRQ_ENGAGED_BIT] = 1'b1;
                end
            end
            cold_load_pickup_pkg::ST_COLD: begin
                if (!cold) begin
                    s_d.st          = cold_load_pickup_pkg::ST_RELEASE;
                    s_d.inrush_seen = 1'b0;
                end
            end
            cold_load_pickup_pkg::ST_RELEASE: begin
                if (over) begin
                    s_d.inrush_seen = 1'b1;
                end
                if (mb_done) begin
                    s_d.st = cold_load_pickup_pkg::ST_WARM;
                    evt[`COLD_LOAD_PICKUP_IRQ_MAXBLK_BIT] = 1'b1;
                end else if (set_done) begin
                    s_d.st = cold_load_pickup_pkg::ST_WARM;
                    evt[`COLD_LOAD_PICKUP_IRQ_SETTLED_BIT] = 1'b1;
                end
            end
        endcase

        // Blocking wins over every transition
        if (blocked) begin
            s_d.st = cold_load_pickup_pkg::ST_WARM;
            evt    = 3'h0;
        end

        // Bus slave: read data and error captured in the setup phase
        if (setup) begin
            s_d.err   = !mapped(paddr_i);
            s_d.rdata = 32'h00000000;
            case (paddr_i)
                `COLD_LOAD_PICKUP_OFS_CTRL: begin
                    s_d.rdata[`COLD_LOAD_PICKUP_CTRL_EN_BIT] = s_q.en;
                    s_d.rdata[`COLD_LOAD_PICKUP_CTRL_MODE_LSB +: 2] = s_q.mode;
                    s_d.rdata[`COLD_LOAD_PICKUP_CTRL_EXT_SEL_BIT] = s_q.ext_sel;
                    s_d.rdata[`COLD_LOAD_PICKUP_CTRL_INT_SEL_BIT] = s_q.int_sel;
                end
                `COLD_LOAD_PICKUP_OFS_STATUS: begin
                    s_d.rdata[2:0] = s_q.st;
                    s_d.rdata[3]   = cold_load_enable_out_o;
                    s_d.rdata[4]   = cold;
                    s_d.rdata[5]   = s_q.inrush_seen;
                    s_d.rdata[6]   = over;
                    s_d.rdata[7]   = blocked;
                end
                `COLD_LOAD_PICKUP_OFS_UC_THR:      s_d.rdata[15:0] = s_q.uc_thr;
                `COLD_LOAD_PICKUP_OFS_INRUSH_THR:  s_d.rdata[15:0] = s_q.inrush_thr;
                `COLD_LOAD_PICKUP_OFS_T_LOAD_OFF:  s_d.rdata[15:0] = s_q.t_load_off;
                `COLD_LOAD_PICKUP_OFS_T_SETTLE:    s_d.rdata[15:0] = s_q.t_settle;
                `COLD_LOAD_PICKUP_OFS_T_MAX_BLOCK: s_d.rdata[15:0] = s_q.t_max_block;
                `COLD_LOAD_PICKUP_OFS_IRQ_STATUS:  s_d.rdata[2:0]  = s_q.irq_st;
                `COLD_LOAD_PICKUP_OFS_IRQ_MASK:    s_d.rdata[2:0]  = s_q.irq_mask;
                default:               s_d.rdata       = 32'h00000000;
            endcase
        end

        if (wr) begin
            case (paddr_i)
                `COLD_LOAD_PICKUP_OFS_CTRL: begin
                    s_d.en      = pwdata_i[`COLD_LOAD_PICKUP_CTRL_EN_BIT];
                    s_d.mode    = cold_load_pickup_pkg::breaker_position_mode_t'(
                                  pwdata_i[`COLD_LOAD_PICKUP_CTRL_MODE_LSB +: 2]);
                    s_d.ext_sel = pwdata_i[`COLD_LOAD_PICKUP_CTRL_EXT_SEL_BIT];
                    s_d.int_sel = pwdata_i[`COLD_LOAD_PICKUP_CTRL_INT_SEL_BIT];
                end
                `COLD_LOAD_PICKUP_OFS_UC_THR:      s_d.uc_thr      = pwdata_i[15:0];
                `COLD_LOAD_PICKUP_OFS_INRUSH_THR:  s_d.inrush_thr  = pwdata_i[15:0];
                `COLD_LOAD_PICKUP_OFS_T_LOAD_OFF:  s_d.t_load_off  = pwdata_i[15:0];
                `COLD_LOAD_PICKUP_OFS_T_SETTLE:    s_d.t_settle    = pwdata_i[15:0];
                `COLD_LOAD_PICKUP_OFS_T_MAX_BLOCK: s_d.t_max_block = pwdata_i[15:0];
                `COLD_LOAD_PICKUP_OFS_IRQ_STATUS:  w1c             = pwdata_i[2:0];
                `COLD_LOAD_PICKUP_OFS_IRQ_MASK:    s_d.irq_mask    = pwdata_i[2:0];
                default: ;
            endcase
        end

        // A new event outlives a clear in the same cycle
        s_d.irq_st = (s_q.irq_st & ~w1c) | evt;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q             <= '0;
            s_q.st          <= cold_load_pickup_pkg::ST_WARM;
            s_q.mode        <= cold_load_pickup_pkg::breaker_position_mode_t'(
                               `COLD_LOAD_PICKUP_RST_MODE);
            s_q.uc_thr      <= `COLD_LOAD_PICKUP_RST_UC_THR;
            s_q.inrush_thr  <= `COLD_LOAD_PICKUP_RST_INRUSH_THR;
            s_q.t_load_off  <= `COLD_LOAD_PICKUP_RST_T_LOAD_OFF;
            s_q.t_settle    <= `COLD_LOAD_PICKUP_RST_T_SETTLE;
            s_q.t_max_block <= `COLD_LOAD_PICKUP_RST_T_MAX_BLOCK;
            s_q.irq_mask    <= `COLD_LOAD_PICKUP_RST_IRQ_MASK;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Indication only; no trip path exists in this block
    assign cold_load_enable_out_o = (s_q.st == cold_load_pickup_pkg::ST_COLD)
                                  | (s_q.st == cold_load_pickup_pkg::ST_RELEASE);
    assign inrush_o  = (s_q.st == cold_load_pickup_pkg::ST_RELEASE) & over;
    assign irq_o     = |(s_q.irq_st & s_q.irq_mask);
    assign prdata_o  = s_q.rdata;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & s_q.err;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_cold_seen;
        s_q.st == cold_load_pickup_pkg::ST_WARM && cold && !blocked;
    endsequence

    sequence s_cold_ends;
        s_q.st == cold_load_pickup_pkg::ST_COLD && !cold && !blocked;
    endsequence

    property p_mode_select;
        (s_q.mode == cold_load_pickup_pkg::MODE_OPEN_AND_UC)
            |-> cold == (!breaker_closed_i && under);
    endproperty
    a_mode_select: assert property (p_mode_select)
        else $error("cold detection does not match AND mode");

    property p_load_off_start;
        s_cold_seen |=> s_q.st == cold_load_pickup_pkg::ST_LOAD_OFF
                        && !cold_load_enable_out_o;
    endproperty
    a_load_off_start: assert property (p_load_off_start)
        else $error("load-off delay did not start");

    property p_enable_cause;
        $rose(cold_load_enable_out_o)
            |-> $past(s_q.st) == cold_load_pickup_pkg::ST_LOAD_OFF && $past(lo_done);
    endproperty
    a_enable_cause: assert property (p_enable_cause)
        else $error("enable rose without load-off expiry");

    property p_inrush_start;
        s_cold_ends |=> s_q.st == cold_load_pickup_pkg::ST_RELEASE
                        && cold_load_enable_out_o && !s_q.inrush_seen;
    endproperty
    a_inrush_start: assert property (p_inrush_start)
        else $error("inrush supervision did not start");

    property p_inrush_flag;
        s_q.st == cold_load_pickup_pkg::ST_RELEASE && over && !blocked && !mb_done
            && !set_done |=> s_q.inrush_seen;
    endproperty
    a_inrush_flag: assert property (p_inrush_flag)
        else $error("inrush not recorded");

    property p_settle_restart;
        s_q.st == cold_load_pickup_pkg::ST_RELEASE && !below_drop
            && s_q.t_settle != 16'h0000 |=> !set_done;
    endproperty
    a_settle_restart: assert property (p_settle_restart)
        else $error("settle timer not restarted above drop point");

    property p_enable_fall;
        $fell(cold_load_enable_out_o)
            |-> $past(set_done) || $past(mb_done) || $past(blocked);
    endproperty
    a_enable_fall: assert property (p_enable_fall)
        else $error("enable released without timer expiry");

    property p_max_block;
        s_q.st == cold_load_pickup_pkg::ST_RELEASE && mb_done
            |=> !cold_load_enable_out_o ##1 !cold_load_enable_out_o;
    endproperty
    a_max_block: assert property (p_max_block)
        else $error("max-block expiry did not clear enable");

    property p_block;
        blocked |=> !cold_load_enable_out_o
                    && s_q.st == cold_load_pickup_pkg::ST_WARM;
    endproperty
    a_block: assert property (p_block)
        else $error("enable present while blocked");

    property p_auto_reclose;
        auto_reclose_running_i |=> !cold_load_enable_out_o;
    endproperty
    a_auto_reclose: assert property (p_auto_reclose)
        else $error("enable present during auto-reclose");

endmodule

`default_nettype wire

/* File: tb/cold_load_pickup_feeder_model.sv */
// Breaker contacts and current front end seen by the supervisor
`timescale 1ns/100ps
`default_nettype none

module cold_load_pickup_feeder_model (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        close_cmd_i,
    input  wire logic [15:0] load_i,
    output logic             breaker_closed_o,
    output logic [15:0]      current_mag_o
);
    // Open contacts carry no load current, so an open breaker reads zero
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            breaker_closed_o <= 1'b0;
            current_mag_o    <= 16'h0000;
        end else begin
            breaker_closed_o <= close_cmd_i;
            current_mag_o    <= close_cmd_i ? load_i : 16'h0000;
        end
    end
endmodule

`default_nettype wire

/* File: tb/cold_load_pickup_logic_bench.sv */
// Self-checking bench for the cold load pickup supervisor
`timescale 1ns/100ps
`default_nettype none
`include "cold_load_pickup_regs.svh"

module cold_load_pickup_logic_bench;
    typedef struct packed {
        logic [1:0]  mode;
        logic [1:0]  sel;
        logic        cls;
        logic [15:0] lvl;
        logic [2:0]  blk;
        logic        exp;
    } row_t;
    localparam int TICK = 4;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        cls = 1'b0;
    logic [15:0] lvl = 16'h0000;
    logic        ext = 1'b0;
    logic        intb = 1'b0;
    logic        reclose = 1'b0;
    logic [31:0] prdata;
    logic [15:0] cur;
    logic        pready, pslverr, closed, en_out, inrush, irq;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [7:0]  radr [9] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
                              8'h1C, 8'h20, 8'h40};
    logic [31:0] rval [9] = '{32'h0, 32'(`COLD_LOAD_PICKUP_RST_UC_THR),
        32'(`COLD_LOAD_PICKUP_RST_INRUSH_THR), 32'(`COLD_LOAD_PICKUP_RST_T_LOAD_OFF),
        32'(`COLD_LOAD_PICKUP_RST_T_SETTLE), 32'(`COLD_LOAD_PICKUP_RST_T_MAX_BLOCK), 32'h0,
        32'(`COLD_LOAD_PICKUP_RST_IRQ_MASK), 32'h0};
    row_t        rows [12] = '{
        {2'h0, 2'h0, 1'h0, 16'h0000, 3'h0, 1'h1},
        {2'h0, 2'h0, 1'h1, 16'h0000, 3'h0, 1'h0},
        {2'h1, 2'h0, 1'h1, 16'h0000, 3'h0, 1'h1},
        {2'h1, 2'h0, 1'h1, 16'h0100, 3'h0, 1'h0},
        {2'h2, 2'h0, 1'h1, 16'h0000, 3'h0, 1'h0},
        {2'h2, 2'h0, 1'h0, 16'h0000, 3'h0, 1'h1},
        {2'h3, 2'h0, 1'h1, 16'h0000, 3'h0, 1'h1},
        {2'h3, 2'h0, 1'h1, 16'h0100, 3'h0, 1'h0},
        {2'h0, 2'h1, 1'h0, 16'h0000, 3'h4, 1'h0},
        {2'h0, 2'h0, 1'h0, 16'h0000, 3'h6, 1'h1},
        {2'h0, 2'h2, 1'h0, 16'h0000, 3'h2, 1'h0},
        {2'h0, 2'h0, 1'h0, 16'h0000, 3'h1, 1'h0}};

    cold_load_pickup_top #(.TICK_CYC(TICK)) DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .breaker_closed_i(closed), .current_mag_i(cur), .ext_block_i(ext),
        .int_block_i(intb), .auto_reclose_running_i(reclose),
        .cold_load_enable_out_o(en_out), .inrush_o(inrush), .irq_o(irq));

    cold_load_pickup_feeder_model feeder (
        .mclk_i(mclk_i), .rst_i(rst_i), .close_cmd_i(cls), .load_i(lvl),
        .breaker_closed_o(closed), .current_mag_o(cur));

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    // ------------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Idle edge before setup: no strobe is assigned twice in one step
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge mclk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        // Only the bench timeout ends a stalled access
        do begin
            @(posedge mclk_i);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic go_cold();
        wr(`COLD_LOAD_PICKUP_OFS_CTRL, 32'h0);
        // Stale events would hide a missing new one
        wr(`COLD_LOAD_PICKUP_OFS_IRQ_STATUS, 32'h7);
        cls  <= 1'b0;
        lvl  <= 16'h0000;
        {ext, intb, reclose} <= 3'h0;
        cyc(2);
        wr(`COLD_LOAD_PICKUP_OFS_CTRL, 32'h1);
    endtask

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Run is under a thousand cycles; the ceiling leaves wide margin
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        cyc(10);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, radr[i], 32'h0, r, e);
            check(r, rval[i]);
            check(e, i == 8);
        end
        wr(`COLD_LOAD_PICKUP_OFS_T_LOAD_OFF, 32'h3);
        wr(`COLD_LOAD_PICKUP_OFS_T_SETTLE, 32'h2);
        wr(`COLD_LOAD_PICKUP_OFS_T_MAX_BLOCK, 32'h14);
        foreach (rows[i]) begin
            wr(`COLD_LOAD_PICKUP_OFS_CTRL, 32'h0);
            cls  <= rows[i].cls;
            lvl  <= rows[i].lvl;
            {ext, intb, reclose} <= rows[i].blk;
            cyc(2);
            wr(`COLD_LOAD_PICKUP_OFS_CTRL, {27'h0, rows[i].sel, rows[i].mode, 1'b1});
            cyc(20);
            check(en_out, rows[i].exp);
        end
        go_cold();
        cyc(10);
        check(en_out, 1'b0);
        cyc(7);
        check(en_out, 1'b1);
        rd(`COLD_LOAD_PICKUP_OFS_IRQ_STATUS, 32'h1);
        cls  <= 1'b1;
        lvl  <= 16'h2000;
        cyc(5);
        check(inrush, 1'b1);
        lvl  <= 16'h0E67;
        cyc(30);
        check(inrush, 1'b0);
        check(en_out, 1'b1);
        lvl  <= 16'h0E66;
        cyc(4);
        check(en_out, 1'b1);
        cyc(10);
        check(en_out, 1'b0);
        rd(`COLD_LOAD_PICKUP_OFS_IRQ_STATUS, 32'h3);
        check(irq, 1'b0);
        wr(`COLD_LOAD_PICKUP_OFS_IRQ_MASK, 32'h2);
        cyc(1);
        check(irq, 1'b1);
        wr(`COLD_LOAD_PICKUP_OFS_IRQ_STATUS, 32'h2);
        cyc(1);
        check(irq, 1'b0);
        rd(`COLD_LOAD_PICKUP_OFS_IRQ_STATUS, 32'h1);
        wr(`COLD_LOAD_PICKUP_OFS_IRQ_STATUS, 32'h7);
        go_cold();
        cyc(17);
        check(en_out, 1'b1);
        cls  <= 1'b1;
        lvl  <= 16'h2000;
        cyc(78);
        check(en_out, 1'b1);
        cyc(8);
        check(en_out, 1'b0);
        rd(`COLD_LOAD_PICKUP_OFS_IRQ_STATUS, 32'h5);
        rd(`COLD_LOAD_PICKUP_OFS_STATUS, 32'h60);
        go_cold();
        cyc(17);
        rst_i <= 1'b1;
        cyc(2);
        check(en_out, 1'b0);
        rst_i <= 1'b0;
        rd(`COLD_LOAD_PICKUP_OFS_T_LOAD_OFF, 32'(`COLD_LOAD_PICKUP_RST_T_LOAD_OFF));
        cyc(20);
        check(en_out, 1'b0);
        finish_test();
    end
endmodule

`default_nettype wire
